/* src/spics_slave.sv */
// Serial command slave: frames command bytes, returns status, dispatches commands
`timescale 1ns/1ns
`default_nettype none

// Function
// - Slave only; interface and output drive active only while chip select low.
// - All transfers are eight-bit words.
// - Bits shift most significant first in both directions.
// - Incoming data sampled on serial clock rising edge.
// - Outgoing bits change on serial clock falling edge.
// - Chip select fall presents status MSB before any clock edge.
// - Command byte either drives controller transitions or opens memory access.
// - Memory commands handled separately, accepted in any controller state.
// - Controller command executes when chip select returns high.
// - Memory command executes on rising edge of first parameter MSB.
// - One command per chip select low period, taken from the first byte.
// - Each received byte returns a status byte with state and ready flags, or read data after a memory command with memRdSel high.
// - Eleven-bit address: top three bits in command low bits, rest next byte.
module spics_slave
    import spics_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic csN,
    output logic miso,
    output logic misoOeN,
    input wire logic [ST_STATE_W-1:0] controllerStateField,
    input wire logic controllerReadyFlag,
    input wire logic memReadyFlag,
    input wire logic memRdSel,
    input wire logic [WORD_BITS-1:0] memRdData,
    output logic rcCmdStrobe,
    output logic [WORD_BITS-1:0] rcCmd,
    output logic memCmdStrobe,
    output logic [WORD_BITS-1:0] memCmd,
    output logic [MEM_ADDR_HI_W-1:0] memAddrHi,
    output logic paramStrobe,
    output logic [WORD_BITS-1:0] paramByte
);
    logic sclkS;
    logic mosiS;
    logic csNS;
    logic sclkP_q, sclkP_d;
    logic csNP_q, csNP_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [1:0] byteCnt_q, byteCnt_d;
    logic [WORD_BITS-1:0] rxShift_q, rxShift_d;
    logic [WORD_BITS-1:0] txShift_q, txShift_d;
    logic [WORD_BITS-1:0] cmd_q, cmd_d;
    logic cmdValid_q, cmdValid_d;
    logic miso_q, miso_d;
    logic misoOeN_q, misoOeN_d;
    logic rcStb_q, rcStb_d;
    logic [WORD_BITS-1:0] rcCmd_q, rcCmd_d;
    logic memStb_q, memStb_d;
    logic [WORD_BITS-1:0] memCmd_q, memCmd_d;
    logic parStb_q, parStb_d;
    logic [WORD_BITS-1:0] parByte_q, parByte_d;
    logic sclkRise, sclkFall, csFall, csRise;
    logic isMem;
    logic [WORD_BITS-1:0] statusWord;
    logic [WORD_BITS-1:0] nextWord;
    logic [WORD_BITS-1:0] rxFull;

    spics_sync #(.W(3), .RST_VAL(SYNC_RESET)) uSync (
        .mclk(mclk),
        .rst(rst),
        .asyncIn({sclk, mosi, csN}),
        .syncOut({sclkS, mosiS, csNS})
    );

    // Edges seen one sync delay late; mclk must run well above the serial clock
    assign sclkRise = sclkS & ~sclkP_q;
    assign sclkFall = ~sclkS & sclkP_q;
    assign csFall = ~csNS & csNP_q;
    assign csRise = csNS & ~csNP_q;
    assign isMem = (cmd_q[MEM_CMD_BIT] == MEM_CMD_VALUE);

    always_comb begin
        statusWord = '0;
        statusWord[ST_MEM_READY_BIT] = memReadyFlag;
        statusWord[ST_CTRL_READY_BIT] = controllerReadyFlag;
        statusWord[ST_STATE_W-1:0] = controllerStateField;
    end

    // Read data replaces status only while a memory command owns the frame
    assign nextWord = (memRdSel && cmdValid_q && isMem) ? memRdData : statusWord;
    assign rxFull = {rxShift_q[WORD_BITS-2:0], mosiS};

    always_comb begin
        sclkP_d = sclkS;
        csNP_d = csNS;
        bitCnt_d = bitCnt_q;
        byteCnt_d = byteCnt_q;
        rxShift_d = rxShift_q;
        txShift_d = txShift_q;
        cmd_d = cmd_q;
        cmdValid_d = cmdValid_q;
        miso_d = miso_q;
        misoOeN_d = csNS;
        rcStb_d = 1'b0;
        rcCmd_d = rcCmd_q;
        memStb_d = 1'b0;
        memCmd_d = memCmd_q;
        parStb_d = 1'b0;
        parByte_d = parByte_q;
        if (csFall) begin
            bitCnt_d = BITCNT_RESET;
            byteCnt_d = BYTECNT_RESET;
            cmdValid_d = 1'b0;
            txShift_d = statusWord;
            miso_d = statusWord[WORD_BITS-1];
        end else if (csRise) begin
            // A partial first byte never sets cmdValid, so nothing runs
            if (cmdValid_q && !isMem && cmd_q != NO_OPERATION_COMMAND) begin
                rcStb_d = 1'b1;
                rcCmd_d = cmd_q;
            end
            cmdValid_d = 1'b0;
        end else if (!csNS) begin
            if (sclkRise) begin
                rxShift_d = rxFull;
                bitCnt_d = bitCnt_q + 3'h1;
                if (bitCnt_q == BITCNT_RESET && byteCnt_q == BYTECNT_PARAM
                    && cmdValid_q && isMem) begin
                    memStb_d = 1'b1;
                    memCmd_d = cmd_q;
                end
                if (bitCnt_q == LAST_BIT) begin
                    if (byteCnt_q == BYTECNT_RESET) begin
                        cmd_d = rxFull;
                        cmdValid_d = 1'b1;
                    end else if (cmdValid_q && isMem) begin
                        parStb_d = 1'b1;
                        parByte_d = rxFull;
                    end
                    // Later bytes of a controller command are ignored
                    if (byteCnt_q != BYTECNT_MAX) begin
                        byteCnt_d = byteCnt_q + 2'h1;
                    end
                end
            end else if (sclkFall) begin
                if (bitCnt_q == BITCNT_RESET) begin
                    txShift_d = nextWord;
                    miso_d = nextWord[WORD_BITS-1];
                end else begin
                    txShift_d = {txShift_q[WORD_BITS-2:0], 1'b0};
                    miso_d = txShift_q[WORD_BITS-2];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclkP_q <= 1'b0;
            csNP_q <= 1'b1;
            bitCnt_q <= BITCNT_RESET;
            byteCnt_q <= BYTECNT_RESET;
            rxShift_q <= SHIFT_RESET;
            txShift_q <= SHIFT_RESET;
            cmd_q <= SHIFT_RESET;
            cmdValid_q <= 1'b0;
            miso_q <= 1'b0;
            misoOeN_q <= 1'b1;
            rcStb_q <= 1'b0;
            rcCmd_q <= SHIFT_RESET;
            memStb_q <= 1'b0;
            memCmd_q <= SHIFT_RESET;
            parStb_q <= 1'b0;
            parByte_q <= SHIFT_RESET;
        end else begin
            sclkP_q <= sclkP_d;
            csNP_q <= csNP_d;
            bitCnt_q <= bitCnt_d;
            byteCnt_q <= byteCnt_d;
            rxShift_q <= rxShift_d;
            txShift_q <= txShift_d;
            cmd_q <= cmd_d;
            cmdValid_q <= cmdValid_d;
            miso_q <= miso_d;
            misoOeN_q <= misoOeN_d;
            rcStb_q <= rcStb_d;
            rcCmd_q <= rcCmd_d;
            memStb_q <= memStb_d;
            memCmd_q <= memCmd_d;
            parStb_q <= parStb_d;
            parByte_q <= parByte_d;
        end
    end

    assign miso = miso_q;
    assign misoOeN = misoOeN_q;
    assign rcCmdStrobe = rcStb_q;
    assign rcCmd = rcCmd_q;
    assign memCmdStrobe = memStb_q;
    assign memCmd = memCmd_q;
    assign memAddrHi = memCmd_q[MEM_ADDR_HI_W-1:0];
    assign paramStrobe = parStb_q;
    assign paramByte = parByte_q;

    sequence s_csFall;
        csFall;
    endsequence
    sequence s_byteDone;
        sclkRise && !csNS && !csFall && bitCnt_q == LAST_BIT;
    endsequence

    property p_oeOff;
        @(posedge mclk) disable iff (rst) csNS |=> misoOeN;
    endproperty
    a_oeOff: assert property (p_oeOff) else $error("miso driven with cs high");

    property p_msbFirst;
        @(posedge mclk) disable iff (rst) s_csFall |=> (miso == $past(statusWord[WORD_BITS-1]));
    endproperty
    a_msbFirst: assert property (p_msbFirst) else $error("status msb not shown");

    property p_frameReset;
        @(posedge mclk) disable iff (rst)
            s_csFall |=> (bitCnt_q == BITCNT_RESET && byteCnt_q == BYTECNT_RESET);
    endproperty
    a_frameReset: assert property (p_frameReset) else $error("framing not reset");

    property p_wordLen;
        @(posedge mclk) disable iff (rst) s_byteDone |=> (bitCnt_q == BITCNT_RESET);
    endproperty
    a_wordLen: assert property (p_wordLen) else $error("word not eight bits");

    property p_sample;
        @(posedge mclk) disable iff (rst)
            (sclkRise && !csNS && !csFall) |=> (rxShift_q[0] == $past(mosiS));
    endproperty
    a_sample: assert property (p_sample) else $error("mosi not sampled");

    property p_shiftOut;
        @(posedge mclk) disable iff (rst)
            (sclkFall && !csNS && !csFall && bitCnt_q != BITCNT_RESET) |=>
            (miso == $past(txShift_q[WORD_BITS-2]));
    endproperty
    a_shiftOut: assert property (p_shiftOut) else $error("miso bit order wrong");

    property p_rcOnRise;
        @(posedge mclk) disable iff (rst) rcCmdStrobe |-> $past(csRise) && $past(cmdValid_q);
    endproperty
    a_rcOnRise: assert property (p_rcOnRise) else $error("controller cmd off cs rise");

    property p_partial;
        @(posedge mclk) disable iff (rst) (csRise && !cmdValid_q) |=> !rcCmdStrobe;
    endproperty
    a_partial: assert property (p_partial) else $error("partial byte executed");

    property p_memExec;
        @(posedge mclk) disable iff (rst)
            memCmdStrobe |-> $past(sclkRise) && $past(byteCnt_q) == BYTECNT_PARAM
            && memCmd[MEM_CMD_BIT] == MEM_CMD_VALUE;
    endproperty
    a_memExec: assert property (p_memExec) else $error("memory cmd wrong edge");

    property p_addrHi;
        @(posedge mclk) disable iff (rst)
            memCmdStrobe |-> memAddrHi == $past(cmd_q[MEM_ADDR_HI_W-1:0]);
    endproperty
    a_addrHi: assert property (p_addrHi) else $error("address high bits wrong");
endmodule

`default_nettype wire

/* src/spics_sync.sv */
// Shared constants and the pin input synchroniser for the serial command port
`timescale 1ns/1ns
`default_nettype none

package spics_pkg;
    localparam int WORD_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] NO_OPERATION_COMMAND = 8'hff;
    localparam int MEM_CMD_BIT = 7;
    localparam logic MEM_CMD_VALUE = 1'h0;
    localparam int MEM_ADDR_HI_W = 3;
    localparam int ST_MEM_READY_BIT = 7;
    localparam int ST_CTRL_READY_BIT = 5;
    localparam int ST_STATE_W = 5;
    localparam logic [2:0] BITCNT_RESET = 3'h0;
    localparam logic [1:0] BYTECNT_RESET = 2'h0;
    localparam logic [1:0] BYTECNT_PARAM = 2'h1;
    localparam logic [1:0] BYTECNT_MAX = 2'h2;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    // Pin idle levels in {sclk, mosi, csN} order: clock low, select high
    localparam logic [2:0] SYNC_RESET = 3'h1;
endpackage

module spics_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;
    logic [W-1:0] stage1_d;
    logic [W-1:0] stage2_d;

    // Stage one feeds only stage two
    always_comb begin
        stage1_d = asyncIn;
        stage2_d = stage1_q;
    end

    // Reset holds each pin's idle level so no false edge follows reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1_q <= RST_VAL;
            stage2_q <= RST_VAL;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign syncOut = stage2_q;
endmodule

`default_nettype wire

/* tb/spi_command_slave_interface_tb_top.sv */
// Self-checking bench for the serial command slave
`timescale 1ns/1ns
`default_nettype none
module spi_command_slave_interface_tb_top;
    import spics_pkg::*;
    logic mclk, rst, sclk, mosi, csN, miso, misoOeN, ctrlRdy, memRdy, memRdSel;
    logic rcCmdStrobe, memCmdStrobe, paramStrobe;
    logic [ST_STATE_W-1:0] stateF;
    logic [7:0] memRdData, rcCmd, memCmd, paramByte, rx;
    logic [MEM_ADDR_HI_W-1:0] memAddrHi;
    logic misoLine;
    int nRc = 0;
    int nMem = 0;
    int nPar = 0;
    int cyc = 0;
    int n_mismatch = 0;
    int checked = 0;
    spics_slave dut (.mclk(mclk), .rst(rst), .sclk(sclk), .mosi(mosi), .csN(csN), .miso(miso),
        .misoOeN(misoOeN), .controllerStateField(stateF), .controllerReadyFlag(ctrlRdy),
        .memReadyFlag(memRdy), .memRdSel(memRdSel), .memRdData(memRdData),
        .rcCmdStrobe(rcCmdStrobe), .rcCmd(rcCmd), .memCmdStrobe(memCmdStrobe),
        .memCmd(memCmd), .memAddrHi(memAddrHi), .paramStrobe(paramStrobe),
        .paramByte(paramByte));
    // Undriven line shows the inverse so the host never trusts a released output
    assign misoLine = misoOeN ? ~miso : miso;
    spics_host_model host (.mclk(mclk), .miso(misoLine), .sclk(sclk), .mosi(mosi), .csN(csN));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rcCmdStrobe === 1'b1) nRc <= nRc + 1;
        if (memCmdStrobe === 1'b1) nMem <= nMem + 1;
        if (paramStrobe === 1'b1) nPar <= nPar + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    function automatic logic [7:0] stat();
        logic [7:0] s;
        s = 8'h00;
        s[ST_MEM_READY_BIT] = memRdy;
        s[ST_CTRL_READY_BIT] = ctrlRdy;
        s[ST_STATE_W-1:0] = stateF;
        return s;
    endfunction
    task automatic t_status(input logic m, input logic c, input logic [4:0] s);
        logic [7:0] e;
        memRdy <= m;
        ctrlRdy <= c;
        stateF <= s;
        @(posedge mclk);
        e = stat();
        check("oe idle", 8'h01, {7'h00, misoOeN});
        host.start();
        check("oe frame", 8'h00, {7'h00, misoOeN});
        check("msb at cs fall", {7'h00, e[7]}, {7'h00, miso});
        host.xfer(NO_OPERATION_COMMAND, 8, rx);
        check("status", e, rx);
        host.stop();
        check("oe after", 8'h01, {7'h00, misoOeN});
    endtask
    task automatic t_rc(input logic [7:0] c, input int extra, input int exp);
        int r0, m0;
        ctrlRdy <= 1'b1;
        host.start();
        host.xfer(NO_OPERATION_COMMAND, 8, rx);
        host.stop();
        check("ctrl ready", 8'h01, {7'h00, rx[ST_CTRL_READY_BIT]});
        r0 = nRc;
        m0 = nMem;
        host.start();
        host.xfer(c, 8, rx);
        repeat (extra) host.xfer(NO_OPERATION_COMMAND, 8, rx);
        check("rc early", 8'h00, 8'(nRc - r0));
        host.stop();
        check("rc count", 8'(exp), 8'(nRc - r0));
        if (exp == 1) check("rc cmd", c, rcCmd);
        check("mem none", 8'h00, 8'(nMem - m0));
    endtask
    task automatic t_mem(input logic [7:0] c, input logic [7:0] p, input logic [7:0] d);
        int r0, m0, p0;
        r0 = nRc;
        m0 = nMem;
        p0 = nPar;
        memRdSel <= 1'b1;
        memRdData <= d;
        memRdy <= 1'b1;
        ctrlRdy <= 1'b0;
        host.start();
        check("mem ready", 8'h01, {7'h00, misoLine});
        host.xfer(c, 8, rx);
        check("mem early", 8'h00, 8'(nMem - m0));
        host.xfer(p, 8, rx);
        check("mem count", 8'h01, 8'(nMem - m0));
        check("rd data", d, rx);
        check("mem cmd", c, memCmd);
        check("addr hi", {5'h00, c[2:0]}, {5'h00, memAddrHi});
        check("param", p, paramByte);
        check("param count", 8'h01, 8'(nPar - p0));
        host.stop();
        check("rc none", 8'h00, 8'(nRc - r0));
        memRdSel <= 1'b0;
    endtask
    // Partial byte then a fresh frame: framing must restart cleanly
    task automatic t_abort();
        int r0, m0;
        r0 = nRc;
        m0 = nMem;
        host.start();
        host.xfer(8'hb5, 5, rx);
        host.stop();
        check("abort rc", 8'h00, 8'(nRc - r0));
        check("abort mem", 8'h00, 8'(nMem - m0));
        t_rc(8'hb5, 0, 1);
    endtask
    initial begin
        rst = 1'b1;
        stateF = 5'h00;
        ctrlRdy = 1'b0;
        memRdy = 1'b0;
        memRdSel = 1'b0;
        memRdData = 8'h00;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_status(1'b1, 1'b0, 5'h15);
        t_status(1'b0, 1'b1, 5'h0a);
        t_status(1'b1, 1'b1, 5'h1f);
        t_rc(8'hb2, 0, 1);
        t_rc(8'hc4, 1, 1);
        t_rc(NO_OPERATION_COMMAND, 1, 0);
        t_mem(8'h1d, 8'h3e, 8'ha5);
        t_mem(8'h0a, 8'hc1, 8'h5a);
        t_abort();
        report_and_stop();
    end
endmodule
`default_nettype wire

/* tb/spics_host_model.sv */
// Host serial master model for the command port
`timescale 1ns/1ns
`default_nettype none
module spics_host_model #(
    parameter int H = 6
) (
    input wire logic mclk,
    input wire logic miso,
    output logic sclk,
    output logic mosi,
    output logic csN
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        csN = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Serial clock stands low outside frames
    task automatic start();
        csN <= 1'b0;
        tick(H);
    endtask
    // Half period of H cycles leaves slack over the two-stage pin sync
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            mosi <= tx[i];
            tick(H);
            rx[i] = miso;
            sclk <= 1'b1;
            tick(H);
            sclk <= 1'b0;
        end
    endtask
    // Host data line toggles in the same cycle select rises so a stale mosi level is never trusted
    task automatic stop();
        tick(H);
        csN <= 1'b1;
        mosi <= ~mosi;
        tick(4 * H);
    endtask
endmodule
`default_nettype wire
